// *** inc/acts_pkg.sv ***
// Package for the conversion trigger sequencer: constants, state encodings and carriers
package acts_pkg;

  // ****************
  // Timing
  // ****************
  localparam int CLK_FREQ_MHZ = 200;
  localparam int PWRUP_TIME_NS = 1000;
  localparam int CONV_TIME_NS = 2000;
  // Least time rounds up, longest time rounds down
  localparam int PWRUP_CYC = (PWRUP_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CONV_CYC = (CONV_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam logic [9:0] PWRUP_LAST = 10'(PWRUP_CYC - 1);
  localparam logic [9:0] CONV_LAST = 10'(CONV_CYC - 1);

  // ****************
  // Bus codes and fields
  // ****************
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [3:0] SEL_RESULT = 4'h0;
  localparam logic [3:0] CMD_FALL_BIT = 4'h5;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] LAST_CHAN_RST = 2'h3;
  // Strap sense {above midpoint, below midpoint}
  localparam logic [1:0] STRAP_VDD = 2'h2;
  localparam logic [1:0] STRAP_GND = 2'h1;
  // Bus addresses per strap state; values are arbitrary
  localparam logic [6:0] ADDR_VDD = 7'h2a;
  localparam logic [6:0] ADDR_GND = 7'h2b;
  localparam logic [6:0] ADDR_FLOAT = 7'h2c;

  // ****************
  // State encodings
  // ****************
  typedef enum logic [7:0] {
    BUS_IDLE = 8'h01, BUS_ADDR = 8'h02, BUS_AACK = 8'h04, BUS_WR = 8'h08,
    BUS_WACK = 8'h10, BUS_RD = 8'h20, BUS_RACK = 8'h40, BUS_SKIP = 8'h80
  } acts_bus_t;

  typedef enum logic [2:0] {
    CNV_SHUT = 3'h1, CNV_PWRUP = 3'h2, CNV_HOLD = 3'h4
  } acts_cnv_t;

  // Analog core control
  typedef struct packed {
    logic power_on;
    logic hold;
    logic [1:0] chan;
  } acts_core_t;

  // Whole state of the sequencer
  typedef struct packed {
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic trg_s1, trg_s2, trg_d;
    logic [1:0] strap_s1, strap_s2;
    acts_bus_t bus;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    logic first_byte;
    logic hs_mode;
    logic [6:0] my_addr;
    logic [3:0] reg_sel;
    logic sda_drv;
    logic scl_hold;
    logic nack;
    logic rd_half;
    logic [15:0] rd_word;
    acts_cnv_t cnv;
    logic [9:0] cnt;
    logic cmd_mode;
    logic [3:0] seq_mask;
    logic [1:0] chan;
    logic invalid;
    logic [15:0] result;
  } acts_state_t;

endpackage : acts_pkg

// *** src/acts_sequencer.sv ***
// Two-wire slave front end and conversion trigger sequencer
`timescale 1ns/1ps
module acts_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Two-wire bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Device pins
  input wire logic conv_trigger_pin,
  input wire logic [1:0] addr_strap_pin,
  // Channel set for trigger-pin mode
  input wire logic [3:0] cfg_channel_bits,
  // Analog core
  input wire logic [11:0] adc_data,
  output acts_pkg::acts_core_t core,
  // Status
  output logic hs_mode,
  output logic cmd_mode,
  output logic result_invalid,
  output logic [3:0] register_select_bits
);
  import acts_pkg::*;

  acts_state_t st_reg;
  acts_state_t st_next;

  // Next channel after 'last' in ascending wrap order among set bits
  function automatic logic [1:0] next_chan(input logic [3:0] mask, input logic [1:0] last);
    logic [1:0] pick;
    logic found;
    logic [1:0] idx;
    pick = last;
    found = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      idx = 2'(last + 2'(i));
      if (!found && mask[idx]) begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction : next_chan

  // ****************
  // Outputs
  // ****************
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = st_reg.scl_hold;
  assign sda_oe = st_reg.sda_drv;
  assign hs_mode = st_reg.hs_mode;
  assign cmd_mode = st_reg.cmd_mode;
  assign result_invalid = st_reg.invalid;
  assign register_select_bits = st_reg.reg_sel;
  assign core.power_on = (st_reg.cnv != CNV_SHUT);
  assign core.hold = (st_reg.cnv == CNV_HOLD);
  assign core.chan = st_reg.chan;

  // ****************
  // Next state
  // ****************
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic trg_rise;
    logic trg_fall;
    logic cnv_busy;
    logic abort_cmd;
    logic [1:0] ch;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    trg_rise = 1'b0;
    trg_fall = 1'b0;
    cnv_busy = 1'b0;
    abort_cmd = 1'b0;
    ch = 2'h0;
    st_next = st_reg;

    // Pins pass two flops; the second stage and, for edge detection, a third delayed copy feed logic
    st_next.scl_s1 = scl_in;
    st_next.scl_s2 = st_reg.scl_s1;
    st_next.scl_d = st_reg.scl_s2;
    st_next.sda_s1 = sda_in;
    st_next.sda_s2 = st_reg.sda_s1;
    st_next.sda_d = st_reg.sda_s2;
    st_next.trg_s1 = conv_trigger_pin;
    st_next.trg_s2 = st_reg.trg_s1;
    st_next.trg_d = st_reg.trg_s2;
    st_next.strap_s1 = addr_strap_pin;
    st_next.strap_s2 = st_reg.strap_s1;

    scl_rise = st_reg.scl_s2 & ~st_reg.scl_d;
    scl_fall = ~st_reg.scl_s2 & st_reg.scl_d;
    start_c = st_reg.scl_s2 & st_reg.scl_d & st_reg.sda_d & ~st_reg.sda_s2;
    stop_c = st_reg.scl_s2 & st_reg.scl_d & ~st_reg.sda_d & st_reg.sda_s2;
    trg_rise = st_reg.trg_s2 & ~st_reg.trg_d;
    trg_fall = ~st_reg.trg_s2 & st_reg.trg_d;
    cnv_busy = (st_reg.cnv != CNV_SHUT);

    // ****************
    // Conversion engine
    // ****************
    case (st_reg.cnv)
      CNV_SHUT: begin
        st_next.cnt = 10'h000;
        if (trg_rise && !st_reg.cmd_mode) begin
          st_next.chan = next_chan(cfg_channel_bits, st_reg.chan);
          st_next.cnv = CNV_PWRUP;
        end
      end
      CNV_PWRUP: begin
        if (st_reg.cmd_mode) begin
          st_next.cnt = 10'(st_reg.cnt + 10'h001);
          if (st_reg.cnt == PWRUP_LAST) begin
            st_next.cnt = 10'h000;
            st_next.invalid = 1'b0;
            st_next.cnv = CNV_HOLD;
          end
        end else begin
          if (st_reg.cnt != PWRUP_LAST) begin
            st_next.cnt = 10'(st_reg.cnt + 10'h001);
          end
          if (trg_fall) begin
            st_next.invalid = (st_reg.cnt != PWRUP_LAST);
            st_next.cnt = 10'h000;
            st_next.cnv = CNV_HOLD;
          end
        end
      end
      CNV_HOLD: begin
        st_next.cnt = 10'(st_reg.cnt + 10'h001);
        if (st_reg.cnt == CONV_LAST) begin
          st_next.result = {2'h0, st_reg.chan, adc_data};
          st_next.cnt = 10'h000;
          st_next.cnv = CNV_SHUT;
        end
      end
      default: begin
        st_next.cnv = CNV_SHUT;
      end
    endcase
    // rises during a conversion fall through unused

    // ****************
    // Bus slave
    // ****************
    if (st_reg.scl_hold && !cnv_busy) begin
      // release once the result is in
      st_next.scl_hold = 1'b0;
    end

    if (stop_c) begin
      st_next.bus = BUS_IDLE;
      st_next.sda_drv = 1'b0;
      st_next.scl_hold = 1'b0;
      st_next.hs_mode = 1'b0;
      abort_cmd = 1'b1;
    end else if (start_c) begin
      // strap decides on first address byte
      if (st_reg.bus == BUS_IDLE) begin
        if (st_reg.strap_s2 == STRAP_VDD) begin
          st_next.my_addr = ADDR_VDD;
        end else if (st_reg.strap_s2 == STRAP_GND) begin
          st_next.my_addr = ADDR_GND;
        end else begin
          st_next.my_addr = ADDR_FLOAT;
        end
      end
      st_next.bus = BUS_ADDR;
      st_next.bit_cnt = 4'h0;
      st_next.sda_drv = 1'b0;
      st_next.first_byte = 1'b1;
      st_next.rd_half = 1'b0;
      st_next.nack = 1'b0;
    end else begin
      case (st_reg.bus)
        BUS_IDLE, BUS_SKIP: begin
          st_next.sda_drv = 1'b0;
        end
        BUS_ADDR: begin
          if (scl_rise) begin
            st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_s2};
            st_next.bit_cnt = 4'(st_reg.bit_cnt + 4'h1);
          end else if (scl_fall && st_reg.bit_cnt == BYTE_BITS) begin
            if (st_reg.shreg[7:3] == HS_CODE_TOP) begin
              st_next.hs_mode = 1'b1;
              st_next.bus = BUS_SKIP;
            end else if (st_reg.shreg[7:1] == st_reg.my_addr) begin
              st_next.sda_drv = 1'b1;
              st_next.rw = st_reg.shreg[0];
              st_next.bus = BUS_AACK;
              // stretch the ack clock while converting
              if (st_reg.shreg[0] && st_reg.hs_mode && st_reg.cmd_mode && cnv_busy) begin
                st_next.scl_hold = 1'b1;
              end
            end else begin
              st_next.bus = BUS_SKIP;
            end
          end
        end
        BUS_AACK, BUS_WACK: begin
          if (scl_fall) begin
            st_next.bit_cnt = 4'h0;
            st_next.sda_drv = 1'b0;
            st_next.bus = BUS_WR;
            if (st_reg.bus == BUS_AACK && st_reg.rw) begin
              st_next.bus = BUS_RD;
              st_next.rd_word = (st_reg.reg_sel == SEL_RESULT) ? st_reg.result : 16'h0000;
              st_next.shreg = st_next.rd_word[15:8];
              st_next.sda_drv = ~st_next.rd_word[15];
              st_next.rd_half = 1'b1;
            end
          end
        end
        BUS_WR: begin
          if (scl_rise) begin
            st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_s2};
            st_next.bit_cnt = 4'(st_reg.bit_cnt + 4'h1);
          end else if (scl_fall && st_reg.first_byte && st_reg.bit_cnt == CMD_FALL_BIT) begin
            st_next.cmd_mode = (st_reg.shreg[4:1] != 4'h0);
            st_next.seq_mask = st_reg.shreg[4:1];
            if (st_reg.shreg[4:1] != 4'h0 && !cnv_busy) begin
              ch = next_chan(st_reg.shreg[4:1], LAST_CHAN_RST);
              st_next.chan = ch;
              st_next.seq_mask[ch] = 1'b0;
              st_next.cnt = 10'h000;
              st_next.cnv = CNV_PWRUP;
            end
          end else if (scl_fall && st_reg.bit_cnt == BYTE_BITS) begin
            if (st_reg.first_byte) begin
              st_next.reg_sel = st_reg.shreg[3:0];
            end
            st_next.first_byte = 1'b0;
            st_next.sda_drv = 1'b1;
            st_next.bus = BUS_WACK;
          end
        end
        BUS_RD: begin
          if (scl_fall) begin
            st_next.bit_cnt = 4'(st_reg.bit_cnt + 4'h1);
            if (st_reg.bit_cnt == 4'h7) begin
              st_next.sda_drv = 1'b0;
              st_next.nack = 1'b0;
              st_next.bus = BUS_RACK;
            end else begin
              st_next.shreg = {st_reg.shreg[6:0], 1'b0};
              st_next.sda_drv = ~st_reg.shreg[6];
            end
          end
        end
        BUS_RACK: begin
          if (scl_rise) begin
            st_next.nack = st_reg.sda_s2;
          end else if (scl_fall) begin
            st_next.bit_cnt = 4'h0;
            if (st_reg.nack) begin
              abort_cmd = 1'b1;
              st_next.bus = BUS_SKIP;
            end else if (st_reg.rd_half) begin
              st_next.shreg = st_reg.rd_word[7:0];
              st_next.sda_drv = ~st_reg.rd_word[7];
              st_next.rd_half = 1'b0;
              st_next.bus = BUS_RD;
            end else begin
              // Further reads repeat the register, fresh data if any
              st_next.rd_word = (st_reg.reg_sel == SEL_RESULT) ? st_reg.result : 16'h0000;
              st_next.shreg = st_next.rd_word[15:8];
              st_next.sda_drv = ~st_next.rd_word[15];
              st_next.rd_half = 1'b1;
              st_next.bus = BUS_RD;
            end
          end
        end
        default: begin
          st_next.bus = BUS_IDLE;
        end
      endcase
    end

    // next channel converts while previous is read
    if (st_reg.cmd_mode && st_reg.seq_mask != 4'h0 && !cnv_busy &&
        st_reg.bus == BUS_RD && st_reg.rd_half && scl_fall && st_reg.bit_cnt == 4'h0) begin
      ch = next_chan(st_reg.seq_mask, LAST_CHAN_RST);
      st_next.chan = ch;
      st_next.seq_mask[ch] = 1'b0;
      st_next.cnt = 10'h000;
      st_next.cnv = CNV_PWRUP;
    end

    // A pin-mode conversion is not disturbed by bus events, except a command write during it, which sets cmd_mode
    if (abort_cmd && st_reg.cmd_mode) begin
      st_next.cmd_mode = 1'b0;
      st_next.seq_mask = 4'h0;
      st_next.scl_hold = 1'b0;
      st_next.cnt = 10'h000;
      st_next.cnv = CNV_SHUT;
    end
  end

  // ****************
  // State register
  // ****************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.scl_s1 <= 1'b1;
      st_reg.scl_s2 <= 1'b1;
      st_reg.scl_d <= 1'b1;
      st_reg.sda_s1 <= 1'b1;
      st_reg.sda_s2 <= 1'b1;
      st_reg.sda_d <= 1'b1;
      st_reg.bus <= BUS_IDLE;
      st_reg.my_addr <= ADDR_FLOAT;
      st_reg.reg_sel <= SEL_RESULT;
      st_reg.chan <= LAST_CHAN_RST;
      st_reg.cnv <= CNV_SHUT;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : acts_sequencer

// *** testbench/acts_master.sv ***
// Two-wire bus master model with open-drain outputs and stretch support
`timescale 1ns/1ps
module acts_master (
  // Wire levels
  input wire logic scl_w,
  input wire logic sda_w,
  // Drive values, 0 pulls the wire low
  output logic scl_m,
  output logic sda_m,
  // A stretch outlasted its bound
  output logic hung
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    hung = 1'b0;
  end

  // ****************
  // Bus primitives, 80 ns SCL period
  // ****************
  task automatic clk_bit(input logic b, output logic r);
    int n;
    n = 0;
    #20 sda_m = b;
    #20 scl_m = 1'b1;
    while (scl_w !== 1'b1 && n < 4000) begin
      #5 n++;
    end
    if (n >= 4000) hung = 1'b1;
    #40 r = sda_w;
    scl_m = 1'b0;
  endtask : clk_bit

  // Also serves as repeated start, since SCL is low after each byte
  task automatic start_c();
    #20 sda_m = 1'b1;
    #20 scl_m = 1'b1;
    #40 sda_m = 1'b0;
    #40 scl_m = 1'b0;
  endtask : start_c

  task automatic stop_c();
    #20 sda_m = 1'b0;
    #20 scl_m = 1'b1;
    #40 sda_m = 1'b1;
    #40;
  endtask : stop_c

  // Eight bits then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                      output logic a_out);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(a_in, a_out);
  endtask : xfer
endmodule : acts_master

// *** testbench/acts_sequencer_chk.sv ***
// Port checks for the conversion trigger sequencer
`timescale 1ns/1ps
module acts_sequencer_chk
  import acts_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Observed pins and status
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic conv_trigger_pin,
  input wire acts_pkg::acts_core_t core,
  input wire logic hs_mode,
  input wire logic cmd_mode
);
  logic [9:0] hold_cnt;
  logic [9:0] pwr_cnt;

  // Run lengths of the hold and power-up phases
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_cnt <= 10'h0;
      pwr_cnt <= 10'h0;
    end else begin
      hold_cnt <= core.hold ? hold_cnt + 10'h1 : 10'h0;
      pwr_cnt <= (core.power_on && !core.hold) ? pwr_cnt + 10'h1 : 10'h0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ****************
  // Assertions
  // ****************
  AST_HOLD_POWERED: assert property (core.hold |-> core.power_on && $stable(core.chan))
    else $error("hold while powered down or channel moved");
  // A conversion in progress only ends in shutdown, never in a fresh power-up
  AST_NO_RETRIGGER: assert property (core.hold |=> core.hold || !core.power_on)
    else $error("new conversion started during a conversion");
  AST_CONV_LENGTH: assert property ($fell(core.hold) |->
    hold_cnt == CONV_LAST + 10'h1 && !core.power_on)
    else $error("conversion length or shutdown wrong");
  AST_TRIG_POWERUP: assert property ($rose(conv_trigger_pin) &&
    !core.power_on && !cmd_mode |-> ##[1:5] core.power_on)
    else $error("trigger rise did not power up");
  AST_FALL_HOLDS: assert property ($fell(conv_trigger_pin) && core.power_on &&
    !core.hold && !cmd_mode |-> ##[1:5] core.hold)
    else $error("trigger fall did not start conversion");
  AST_CMD_POWERUP: assert property ($rose(core.hold) && cmd_mode |->
    pwr_cnt == PWRUP_LAST + 10'h1)
    else $error("command power-up length wrong");
  AST_STOP_HS: assert property (scl_in && $past(scl_in) && sda_in &&
    !$past(sda_in) |-> ##[1:5] !hs_mode)
    else $error("high speed kept after stop");
  AST_STOP_CMD: assert property (scl_in && $past(scl_in) && sda_in &&
    !$past(sda_in) && cmd_mode |-> ##[1:5] (!cmd_mode && !core.power_on))
    else $error("command sequence kept after stop");
  AST_STRETCH_HS: assert property (scl_oe |-> hs_mode)
    else $error("clock stretched outside high speed");
  AST_STRETCH_END: assert property (scl_oe && !core.power_on |-> ##[1:3] !scl_oe)
    else $error("stretch held after conversion");
endmodule : acts_sequencer_chk

bind acts_sequencer acts_sequencer_chk u_chk (
  .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .scl_oe(scl_oe), .sda_in(sda_in),
  .conv_trigger_pin(conv_trigger_pin), .core(core), .hs_mode(hs_mode),
  .cmd_mode(cmd_mode)
);

// *** testbench/acts_sequencer_tb.sv ***
// Self-checking bench for the conversion trigger sequencer
`timescale 1ns/1ps
module acts_sequencer_tb;
  import acts_pkg::*;
  logic clock, rst_n, trig, scl_oe, sda_oe, scl_m, sda_m, hung, stretched, a;
  logic [1:0] strap;
  logic [3:0] cfg, sel;
  logic [11:0] adc;
  logic [7:0] q;
  acts_core_t core;
  logic hs, cmd, inval;
  logic scl_o, sda_o;
  int error_cnt, checks_done;
  // Open-drain wires with pull-ups; the driven level comes from the design
  wire scl_w = scl_m & ~(scl_oe & ~scl_o);
  wire sda_w = sda_m & ~(sda_oe & ~sda_o);

  acts_sequencer u_dut (
    .clock(clock), .rst_n(rst_n), .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe), .conv_trigger_pin(trig),
    .addr_strap_pin(strap), .cfg_channel_bits(cfg), .adc_data(adc), .core(core),
    .hs_mode(hs), .cmd_mode(cmd), .result_invalid(inval), .register_select_bits(sel)
  );
  acts_master u_master (
    .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m), .hung(hung)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Sample value names its channel
  always @(negedge clock) adc <= {10'h2d3, core.chan};
  always @(posedge clock) if (scl_oe === 1'b1) stretched <= 1'b1;

  // ****************
  // Common tasks
  // ****************
  task automatic close_out();
    if (hung !== 1'b0) error_cnt++;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic do_reset(input logic [1:0] s);
    @(negedge clock);
    strap = s;
    rst_n = 1'b0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask : do_reset

  task automatic wait_pwr(input logic v);
    int n;
    n = 0;
    while (core.power_on !== v && n < 2000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      close_out();
    end
  endtask : wait_pwr

  task automatic wr_ptr(input logic [7:0] p);
    u_master.start_c();
    u_master.xfer({ADDR_VDD, 1'b0}, 1'b1, q, a);
    u_master.xfer(p, 1'b1, q, a);
  endtask : wr_ptr

  task automatic rd_start();
    u_master.start_c();
    u_master.xfer({ADDR_VDD, 1'b1}, 1'b1, q, a);
  endtask : rd_start

  task automatic rd_pair(input logic [1:0] ch, input logic last, input int gap);
    logic [11:0] d;
    d = {10'h2d3, ch};
    u_master.xfer(8'hff, 1'b0, q, a);
    chk("result high", {10'h0, ch, d[11:8]}, {8'h0, q});
    // SCL held low between bytes; the next pair is fetched at this pair's last ack
    repeat (gap) @(negedge clock);
    u_master.xfer(8'hff, last, q, a);
    chk("result low", {8'h0, d[7:0]}, {8'h0, q});
  endtask : rd_pair

  // ****************
  // Scenarios
  // ****************
  task automatic s_strap();
    logic [1:0] sv[3] = '{STRAP_GND, 2'h0, STRAP_VDD};
    logic [6:0] av[3] = '{ADDR_GND, ADDR_FLOAT, ADDR_VDD};
    for (int i = 0; i < 3; i++) begin
      do_reset(sv[i]);
      u_master.start_c();
      u_master.xfer({av[i], 1'b0}, 1'b1, q, a);
      chk("own address ack", 16'h0, {15'h0, a});
      u_master.stop_c();
      u_master.start_c();
      u_master.xfer({av[(i + 1) % 3], 1'b0}, 1'b1, q, a);
      chk("other address ack", 16'h1, {15'h0, a});
      u_master.stop_c();
    end
  endtask : s_strap

  task automatic s_pin();
    cfg = 4'h5;
    wr_ptr(8'h00);
    u_master.stop_c();
    chk("select bits", 16'h0, {12'h0, sel});
    chk("idle power", 16'h0, {15'h0, core.power_on});
    trig = 1'b1;
    repeat (250) @(negedge clock);
    trig = 1'b0;
    repeat (20) @(negedge clock);
    chk("hold", 16'h1, {15'h0, core.hold});
    // Second pulse lands inside the conversion
    trig = 1'b1;
    repeat (20) @(negedge clock);
    trig = 1'b0;
    wait_pwr(1'b0);
    repeat (20) @(negedge clock);
    chk("power after conversion", 16'h0, {15'h0, core.power_on});
    chk("invalid flag", 16'h0, {15'h0, inval});
    rd_start();
    rd_pair(2'h0, 1'b1, 0);
    u_master.stop_c();
    trig = 1'b1;
    repeat (50) @(negedge clock);
    trig = 1'b0;
    repeat (10) @(negedge clock);
    wait_pwr(1'b0);
    chk("invalid flag", 16'h1, {15'h0, inval});
    rd_start();
    rd_pair(2'h2, 1'b1, 0);
    u_master.stop_c();
  endtask : s_pin

  task automatic s_cmd();
    wr_ptr(8'h10);
    u_master.stop_c();
    repeat (10) @(negedge clock);
    chk("command after stop", 16'h0, {14'h0, cmd, core.power_on});
    wr_ptr(8'h50);
    chk("command start", 16'h3, {14'h0, cmd, core.power_on});
    chk("first channel", 16'h0, {14'h0, core.chan});
    repeat (700) @(negedge clock);
    rd_start();
    rd_pair(2'h0, 1'b0, 700);
    rd_pair(2'h2, 1'b1, 0);
    repeat (10) @(negedge clock);
    chk("command after nack", 16'h0, {14'h0, cmd, core.power_on});
    u_master.stop_c();
  endtask : s_cmd

  task automatic s_hs();
    u_master.start_c();
    u_master.xfer(8'h09, 1'b1, q, a);
    chk("master code ack", 16'h1, {15'h0, a});
    chk("high speed", 16'h1, {15'h0, hs});
    wr_ptr(8'h80);
    rd_start();
    chk("read address ack", 16'h0, {15'h0, a});
    chk("stretched", 16'h1, {15'h0, stretched});
    rd_pair(2'h3, 1'b1, 0);
    u_master.stop_c();
    repeat (10) @(negedge clock);
    chk("high speed after stop", 16'h0, {15'h0, hs});
  endtask : s_hs

  initial begin
    rst_n = 1'b0;
    trig = 1'b0;
    strap = STRAP_VDD;
    cfg = 4'h0;
    stretched = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    s_strap();
    s_pin();
    s_cmd();
    s_hs();
    close_out();
  end

  initial begin
    #450000;
    error_cnt++;
    close_out();
  end
endmodule : acts_sequencer_tb
